// File: hw/cam_pkg.sv
package cam_pkg;

    // array geometry
    localparam int CAM_DEPTH  = 32;
    localparam int CAM_WIDTH  = 32;
    localparam int CAM_OUT_W  = 16;
    localparam int CAM_ADDR_W = 5;

    // reset values of the result path
    localparam logic       CAM_MATCH_RST  = 1'b0;
    localparam logic [15:0] CAM_RESULT_RST = 16'h0000;

    // write timing in clock cycles
    localparam int CAM_WR_CYCLES      = 2;
    localparam int CAM_WR_MASK_CYCLES = 3;

    // output mode select values
    localparam logic CAM_MODE_ENCODED   = 1'b0;
    localparam logic CAM_MODE_UNENCODED = 1'b1;

    // write sequencer states
    typedef enum logic [1:0] {
        CAM_WR_IDLE,
        CAM_WR_HOLD,
        CAM_WR_MASK
    } cam_wr_state_t;

endpackage

// File: hw/cam_match_if.sv
`timescale 1ns/100ps
interface cam_match_if #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 32
);
    logic [WIDTH-1:0]            key;
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [DEPTH-1:0][WIDTH-1:0] care;
    logic [DEPTH-1:0]            hit;

    modport requester (output key, output words, output care, input hit);
    modport matcher   (input key, input words, input care, output hit);
endinterface

// File: hw/cam_match.sv
`timescale 1ns/100ps
module cam_match #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 32
) (
    cam_match_if.matcher m
);

    // one masked comparator per entry, all working at once
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        assign m.hit[i] = ((m.words[i] ^ m.key) & m.care[i]) == '0;
    end

endmodule

// File: hw/cam_top.sv
`timescale 1ns/100ps
module cam_top #(
    parameter int                              DEPTH      = cam_pkg::CAM_DEPTH,
    parameter int                              WIDTH      = cam_pkg::CAM_WIDTH,
    parameter int                              OUT_W      = cam_pkg::CAM_OUT_W,
    parameter int                              ADDR_W     = cam_pkg::CAM_ADDR_W,
    parameter logic [DEPTH-1:0][WIDTH-1:0]     INIT_WORDS = '0,
    parameter logic [DEPTH-1:0][WIDTH-1:0]     INIT_CARE  = '1
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              local_clr_i,
    input  wire logic              global_clr_i,
    input  wire logic              wr_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [WIDTH-1:0]  wr_data_i,
    input  wire logic              wr_mask_en_i,
    input  wire logic [WIDTH-1:0]  wr_care_i,
    output logic                   wr_busy_o,
    input  wire logic              srch_i,
    input  wire logic [WIDTH-1:0]  srch_data_i,
    input  wire logic              srch_mode_i,
    output logic                   srch_rdy_o,
    output logic                   valid_o,
    output logic                   match_o,
    output logic                   upper_half_o,
    output logic [OUT_W-1:0]       result_o
);

    // elaboration checks on geometry
    if (DEPTH != 2 * OUT_W) begin : g_chk_depth
        $error("cam_top: DEPTH must be twice OUT_W");
    end
    if ((1 << ADDR_W) != DEPTH) begin : g_chk_addr
        $error("cam_top: ADDR_W must address DEPTH exactly");
    end
    if (ADDR_W > OUT_W) begin : g_chk_out
        $error("cam_top: encoded address must fit the output bus");
    end

    // either clear input resets every register at once, storage to its preload image
    logic async_clr;
    assign async_clr = local_clr_i | global_clr_i;

    // ------------------------------------------------------------------
    // storage: words plus per-bit compare enables (1 = compare)
    // ------------------------------------------------------------------
    // storage geometry
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [DEPTH-1:0][WIDTH-1:0] care;
    logic [DEPTH-1:0][WIDTH-1:0] next_words;
    logic [DEPTH-1:0][WIDTH-1:0] next_care;

    // write sequencer state and captured request
    cam_pkg::cam_wr_state_t wr_state;
    cam_pkg::cam_wr_state_t next_wr_state;
    logic [ADDR_W-1:0]      wr_addr;
    logic [ADDR_W-1:0]      next_wr_addr;
    logic [WIDTH-1:0]       wr_data;
    logic [WIDTH-1:0]       next_wr_data;
    logic [WIDTH-1:0]       wr_care;
    logic [WIDTH-1:0]       next_wr_care;
    logic                   wr_masked;
    logic                   next_wr_masked;
    logic                   wr_commit;

    // sequencer busy while a write is in flight
    assign wr_busy_o = (wr_state != cam_pkg::CAM_WR_IDLE);

    // write sequencer next state
    always_comb begin
        next_wr_state  = wr_state;
        next_wr_addr   = wr_addr;
        next_wr_data   = wr_data;
        next_wr_care   = wr_care;
        next_wr_masked = wr_masked;
        wr_commit      = 1'b0;
        unique case (wr_state)
            cam_pkg::CAM_WR_IDLE: begin
                if (wr_i) begin
                    next_wr_state  = cam_pkg::CAM_WR_HOLD;
                    next_wr_addr   = wr_addr_i;
                    next_wr_data   = wr_data_i;
                    next_wr_care   = wr_mask_en_i ? wr_care_i : '1;
                    next_wr_masked = wr_mask_en_i;
                end
            end
            cam_pkg::CAM_WR_HOLD: begin
                if (wr_masked) begin
                    next_wr_state = cam_pkg::CAM_WR_MASK;
                end else begin
                    wr_commit     = 1'b1;
                    next_wr_state = cam_pkg::CAM_WR_IDLE;
                end
            end
            cam_pkg::CAM_WR_MASK: begin
                wr_commit     = 1'b1;
                next_wr_state = cam_pkg::CAM_WR_IDLE;
            end
        endcase
        if (!rst_n_i) begin
            next_wr_state  = cam_pkg::CAM_WR_IDLE;
            next_wr_addr   = '0;
            next_wr_data   = '0;
            next_wr_care   = '0;
            next_wr_masked = 1'b0;
        end
    end

    // write sequencer registers
    always_ff @(posedge core_clk_i or posedge async_clr) begin
        if (async_clr) begin
            wr_state  <= cam_pkg::CAM_WR_IDLE;
            wr_addr   <= '0;
            wr_data   <= '0;
            wr_care   <= '0;
            wr_masked <= 1'b0;
        end else begin
            wr_state  <= next_wr_state;
            wr_addr   <= next_wr_addr;
            wr_data   <= next_wr_data;
            wr_care   <= next_wr_care;
            wr_masked <= next_wr_masked;
        end
    end

    // storage next values: committed write or preload on reset
    always_comb begin
        next_words = words;
        next_care  = care;
        if (wr_commit) begin
            next_words[wr_addr] = wr_data;
            next_care[wr_addr]  = wr_care;
        end
        if (!rst_n_i) begin
            next_words = INIT_WORDS;
            next_care  = INIT_CARE;
        end
    end

    // storage registers, clear restores the preload image
    always_ff @(posedge core_clk_i or posedge async_clr) begin
        if (async_clr) begin
            words <= INIT_WORDS;
            care  <= INIT_CARE;
        end else begin
            words <= next_words;
            care  <= next_care;
        end
    end

    // ------------------------------------------------------------------
    // parallel comparison
    // ------------------------------------------------------------------
    cam_match_if #(.DEPTH(DEPTH), .WIDTH(WIDTH)) cmp_if ();

    assign cmp_if.key   = srch_data_i;
    assign cmp_if.words = words;
    assign cmp_if.care  = care;

    cam_match #(
        .DEPTH (DEPTH),
        .WIDTH (WIDTH)
    ) u_match (
        .m (cmp_if.matcher)
    );

    // lowest matching index for encoded output
    logic [ADDR_W-1:0] hit_addr;
    logic              any_hit;

    always_comb begin
        hit_addr = '0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (cmp_if.hit[i]) begin
                hit_addr = ADDR_W'(i);
            end
        end
        any_hit = |cmp_if.hit;
    end

    // ------------------------------------------------------------------
    // result path
    // ------------------------------------------------------------------
    logic             valid;
    logic             next_valid;
    logic             match;
    logic             next_match;
    logic             upper_half;
    logic             next_upper_half;
    logic [OUT_W-1:0] result;
    logic [OUT_W-1:0] next_result;
    logic [OUT_W-1:0] held_hi;
    logic [OUT_W-1:0] next_held_hi;
    logic             hi_pending;
    logic             next_hi_pending;
    logic             srch_take;

    // no new search while the upper half is still owed
    assign srch_rdy_o = ~hi_pending;
    assign srch_take  = srch_i & ~hi_pending;

    // result next values
    always_comb begin
        next_valid      = 1'b0;
        next_match      = match;
        next_upper_half = 1'b0;
        next_result     = result;
        next_held_hi    = held_hi;
        next_hi_pending = 1'b0;
        if (hi_pending) begin
            next_valid      = 1'b1;
            next_upper_half = 1'b1;
            next_result     = held_hi;
        end else if (srch_take) begin
            next_valid = 1'b1;
            next_match = any_hit;
            if (srch_mode_i == cam_pkg::CAM_MODE_UNENCODED) begin
                next_result     = cmp_if.hit[OUT_W-1:0];
                next_held_hi    = cmp_if.hit[DEPTH-1:OUT_W];
                next_hi_pending = 1'b1;
            end else begin
                next_result = OUT_W'(hit_addr);
            end
        end
        if (!rst_n_i) begin
            next_valid      = 1'b0;
            next_match      = cam_pkg::CAM_MATCH_RST;
            next_upper_half = 1'b0;
            next_result     = OUT_W'(cam_pkg::CAM_RESULT_RST);
            next_held_hi    = '0;
            next_hi_pending = 1'b0;
        end
    end

    // result registers
    always_ff @(posedge core_clk_i or posedge async_clr) begin
        if (async_clr) begin
            valid      <= 1'b0;
            match      <= cam_pkg::CAM_MATCH_RST;
            upper_half <= 1'b0;
            result     <= OUT_W'(cam_pkg::CAM_RESULT_RST);
            held_hi    <= '0;
            hi_pending <= 1'b0;
        end else begin
            valid      <= next_valid;
            match      <= next_match;
            upper_half <= next_upper_half;
            result     <= next_result;
            held_hi    <= next_held_hi;
            hi_pending <= next_hi_pending;
        end
    end

    // outputs straight from flip-flops
    assign valid_o      = valid;
    assign match_o      = match;
    assign upper_half_o = upper_half;
    assign result_o     = result;

endmodule

// File: testbench/cam_beat_capture.sv
`timescale 1ns/100ps
module cam_beat_capture (
    input  wire logic        clk_i,
    input  wire logic        valid_i,
    input  wire logic        upper_i,
    input  wire logic [15:0] res_i,
    output logic      [31:0] vec_o
);
    always @(posedge clk_i) begin
        if (valid_i === 1'b1) begin
            if (upper_i) vec_o[31:16] <= res_i;
            else vec_o[15:0] <= res_i;
        end
    end
endmodule

// File: testbench/cam_top_monitor.sv
`timescale 1ns/100ps
module cam_top_monitor #(
    parameter int OUT_W = 16
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             local_clr_i,
    input  wire logic             global_clr_i,
    input  wire logic             wr_i,
    input  wire logic             wr_mask_en_i,
    input  wire logic             wr_busy_o,
    input  wire logic             srch_i,
    input  wire logic             srch_mode_i,
    input  wire logic             srch_rdy_o,
    input  wire logic             valid_o,
    input  wire logic             match_o,
    input  wire logic             upper_half_o,
    input  wire logic [OUT_W-1:0] result_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i || local_clr_i || global_clr_i);
    logic take;
    // search accepted this cycle
    assign take = srch_i && srch_rdy_o;
    a_valid_after_take: assert property (
        take |=> valid_o)
        else $error("no beat after search");
    a_idle_no_beat: assert property (
        srch_rdy_o && !take |=> !valid_o)
        else $error("beat without search");
    a_upper_beat: assert property (
        take && srch_mode_i |=> !upper_half_o ##1 (valid_o && upper_half_o))
        else $error("upper beat missing");
    a_owed_not_rdy: assert property (
        take && srch_mode_i |=> !srch_rdy_o ##1 srch_rdy_o)
        else $error("ready wrong in split result");
    a_plain_write: assert property (
        wr_i && !wr_busy_o && !wr_mask_en_i |=> wr_busy_o ##1 !wr_busy_o)
        else $error("plain write length");
    a_mask_write: assert property (
        wr_i && !wr_busy_o && wr_mask_en_i |=> wr_busy_o[*2] ##1 !wr_busy_o)
        else $error("masked write length");
    a_miss_zero: assert property (
        valid_o && !match_o |-> result_o == '0)
        else $error("result set without match");
    a_enc_range: assert property (
        valid_o && !upper_half_o && !$past(srch_mode_i) |-> (result_o >> 5) == '0)
        else $error("encoded index out of range");
    a_match_any: assert property (
        valid_o && upper_half_o |-> match_o == (|result_o || |$past(result_o)))
        else $error("match flag disagrees with lines");
    a_clear_out: assert property (
        disable iff (!rst_n_i)
        (local_clr_i || global_clr_i) |-> !valid_o && !match_o && !wr_busy_o
            && srch_rdy_o && !upper_half_o && result_o == '0)
        else $error("outputs not cleared");
endmodule
bind cam_top cam_top_monitor #(.OUT_W(OUT_W)) u_mon (.core_clk_i, .rst_n_i, .local_clr_i,
    .global_clr_i, .wr_i, .wr_mask_en_i, .wr_busy_o, .srch_i, .srch_mode_i, .srch_rdy_o,
    .valid_o, .match_o, .upper_half_o, .result_o);

// File: testbench/tb_content_addressable_memory.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_content_addressable_memory;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        local_clr_i = 1'b0;
    logic        global_clr_i = 1'b0;
    logic        wr_i = 1'b0;
    logic [4:0]  wr_addr_i = 5'h00;
    logic [31:0] wr_data_i = 32'h0;
    logic        wr_mask_en_i = 1'b0;
    logic [31:0] wr_care_i = 32'h0;
    logic        srch_i = 1'b0;
    logic [31:0] srch_data_i = 32'h0;
    logic        srch_mode_i = 1'b0;
    logic        wr_busy_o, srch_rdy_o, valid_o, match_o, upper_half_o;
    logic [15:0] result_o;
    logic [31:0] vec, k;
    logic [31:0] w [32];
    logic [31:0] c [32];
    logic [16:0] q [$];
    logic [16:0] e;
    int          miscompares = 0;
    int          n_tests = 0;
    integer      seed = 24414;

    always #2 core_clk_i = ~core_clk_i;

    cam_top DUT (.core_clk_i, .rst_n_i, .local_clr_i, .global_clr_i, .wr_i, .wr_addr_i,
        .wr_data_i, .wr_mask_en_i, .wr_care_i, .wr_busy_o, .srch_i, .srch_data_i,
        .srch_mode_i, .srch_rdy_o, .valid_o, .match_o, .upper_half_o, .result_o);
    cam_beat_capture u_cap (.clk_i(core_clk_i), .valid_i(valid_o), .upper_i(upper_half_o),
        .res_i(result_o), .vec_o(vec));

    // reference compare of a key against the model
    function automatic logic [31:0] hits(input logic [31:0] key);
        for (int i = 0; i < 32; i++) hits[i] = ((key ^ w[i]) & c[i]) == 32'h0;
    endfunction

    task automatic clr_model;
        for (int i = 0; i < 32; i++) begin
            w[i] = 32'h0;
            c[i] = 32'hFFFFFFFF;
        end
    endtask

    task automatic wr(input int a, input logic [31:0] d, input logic m, input logic [31:0] ck);
        srch_i = 1'b0;
        wr_i = 1'b1;
        wr_addr_i = a[4:0];
        wr_data_i = d;
        wr_mask_en_i = m;
        wr_care_i = ck;
        @(posedge core_clk_i);
        #1 wr_i = 1'b0;
        w[a] = d;
        c[a] = m ? ck : 32'hFFFFFFFF;
        repeat (m ? 2 : 1) @(posedge core_clk_i);
        #1;
    endtask

    task automatic srch(input logic [31:0] key, input logic m);
        logic [31:0] h;
        int          lo;
        h = hits(key);
        lo = 0;
        for (int i = 31; i >= 0; i--) if (h[i]) lo = i;
        if (m) begin
            q.push_back({|h, h[15:0]});
            q.push_back({|h, h[31:16]});
        end else q.push_back({|h, 16'(lo)});
        srch_i = 1'b1;
        srch_data_i = key;
        srch_mode_i = m;
        @(posedge core_clk_i);
        #1;
        if (m) begin
            srch_i = 1'b0;
            @(posedge core_clk_i);
            #1;
        end
    endtask

    task automatic settle;
        srch_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // compare each beat with the oldest note
    always @(posedge core_clk_i) begin
        if (valid_o === 1'b1) begin
            e = q.size() ? q.pop_front() : {1'bx, 16'hXXXX};
            `CHK("beat", e, {match_o, result_o})
        end
    end

    initial begin
        #20000;
        miscompares++;
        final_report;
    end

    initial begin
        clr_model;
        repeat (3) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        srch(32'h0, 1'b1);
        for (int i = 0; i < 32; i++) wr(i, $random(seed), 1'b0, 32'h0);
        for (int i = 0; i < 32; i++) srch(w[i], 1'b0);
        srch(~w[5], 1'b0);
        settle;
        $display("encoded search test done");
        k = $random(seed);
        wr(7, $random(seed), 1'b1, k);
        srch(w[7] ^ ~k, 1'b0);
        srch(w[7] ^ (k & ~(k - 32'h1)), 1'b0);
        settle;
        $display("masked write test done");
        wr(20, w[3], 1'b0, 32'h0);
        srch(w[3], 1'b1);
        settle;
        `CHK("vector", hits(w[3]), vec)
        $display("unencoded duplicate test done");
        // each clear input acts alone, local first, then global
        for (int j = 0; j < 2; j++) begin
            local_clr_i = (j == 0);
            global_clr_i = (j == 1);
            #1;
            `CHK("clear", 20'h40000, {wr_busy_o, srch_rdy_o, valid_o, match_o, result_o})
            @(posedge core_clk_i);
            #1 local_clr_i = 1'b0;
            global_clr_i = 1'b0;
            clr_model;
            srch(32'h0, 1'b1);
            settle;
            `CHK("vector", 32'hFFFFFFFF, vec)
        end
        $display("clear test done");
        final_report;
    end
endmodule
